// >>> core/ucs_engine.sv
// Purpose: serial interface engine for a low-speed control endpoint 0
// Assumes: a packet decoder in front delivers tokens, bytes and a packet verdict
// Notes:   only endpoint 0 is served; other endpoint numbers are ignored
//
// How it works
// RQ1: setup flag sets when the setup data phase starts
// RQ2: acked transaction locks mode and count writes
// RQ3: only a cpu read after completion unlocks
// RQ4: lock lasts about one microsecond
// RQ5: firmware reads mode first in its handler
// RQ6: good setup stores, flags, goes nak in/out, acks, interrupts
// RQ7: oversize setup updates toggle/valid/count/setup flag, silent, interrupts
// RQ8: bad setup updates toggle/count, clears valid, silent, interrupts
// RQ9: ack-out status-in acks good out, moves to nak-out status-in
// RQ10: nak-out status-in naks good out, sets out flag and interrupts, mode unchanged
// RQ11: status-in-only stalls good out, moves to stall in/out
// RQ12: mode resets disabled, stays until firmware writes
// RQ13: packet good only if ten bytes or fewer, error free
// RQ14: status-in modes answer in with zero-length packet, interrupt
//
// The address map and the strobed register port were chosen for this implementation.
module ucs_engine #(
  parameter int LOCK_CYCLES = ucs_pkg::LOCK_CYCLES,
  parameter int MAX_BYTES   = ucs_pkg::MAX_BYTES
) (
  input  wire logic               CLK,       // clock, 250 MHz
  input  wire logic               RESETN,    // async reset, low
  input  wire logic               TOK_VALID, // token pulse
  input  wire ucs_pkg::ucs_tok_t  TOK,       // token kind and endpoint
  input  wire logic               DAT_START, // data phase start pulse
  input  wire logic               BYTE_VALID,// received byte pulse
  input  wire ucs_pkg::ucs_byte_t RX_BYTE,   // received byte
  input  wire logic               PKT_END,   // data packet end pulse
  input  wire ucs_pkg::ucs_pkt_t  PKT,       // packet verdict at end
  input  wire logic               HS_ACK,    // host ack to our in data
  output ucs_pkg::ucs_resp_t      RESP,      // handshake to send
  output logic                    RESP_VALID,// response pulse
  input  wire logic [7:0]         ADDR,      // register address
  input  wire logic [7:0]         WDATA,     // write data
  input  wire logic               WR,        // write strobe
  input  wire logic               RD,        // read strobe
  output logic [7:0]              RDATA,     // read data
  output logic                    IRQ        // interrupt, high active
);
  // ==========================================================
  // state
  // ==========================================================
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_DATA = 3'b010,
    ST_WAIT = 3'b100
  } ucs_st_t;

  ucs_st_t            state;
  ucs_pkg::ucs_token_t cur_tok;
  logic [3:0]          mode;
  logic                f_setup;
  logic                f_in;
  logic                f_out;
  logic                f_ack;
  logic [3:0]          count;
  logic                dval;
  logic                toggle;
  logic [7:0]          buffer [0:9];
  logic [3:0]          wptr;
  logic                locked;
  logic                ack_done;
  logic                ev;
  logic [7:0]          irq_status;
  logic [7:0]          irq_mask;
  logic                ucs_hit_rd;
  logic                rd_stat;

  logic                is_ep0;
  logic                setup_ok;
  logic                out_ok;
  logic                big;
  logic                good;
  logic                stin;
  logic                wr_mode;
  logic                wr_cnt;
  logic [7:0]          next_rdata;

  assign is_ep0   = (TOK.ep == 4'h0);
  // setup accepted only in control modes
  assign setup_ok = !(mode inside {4'h0, 4'h5, 4'h7, 4'h8, 4'h9, 4'hC, 4'hD});
  assign stin     = mode inside {ucs_pkg::MODE_NAKOUT_STIN, ucs_pkg::MODE_ACKOUT_STIN, ucs_pkg::MODE_STATUS_IN};
  assign out_ok   = (mode == ucs_pkg::MODE_ACKOUT_STIN);
  assign big      = (PKT.count > 5'(MAX_BYTES));                 // see RQ13
  assign good     = PKT.ok && !big;                              // see RQ13
  assign wr_mode  = WR && (ADDR == ucs_pkg::ADDR_MODE) && !locked;
  assign wr_cnt   = WR && (ADDR == ucs_pkg::ADDR_COUNT) && !locked;

  // ==========================================================
  // transaction sequencing
  // ==========================================================
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state   <= ST_IDLE;
      cur_tok <= ucs_pkg::TOK_SETUP;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (TOK_VALID && is_ep0 && mode != ucs_pkg::MODE_DISABLED)   // see RQ12
          begin
            cur_tok <= TOK.token;
            if (TOK.token == ucs_pkg::TOK_IN)
              state <= stin ? ST_WAIT : ST_IDLE;
            else
              state <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (PKT_END)
            state <= ST_IDLE;
        end
        ST_WAIT:
        begin
          if (HS_ACK || TOK_VALID)
            state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // responses
  // ==========================================================
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      RESP       <= ucs_pkg::RSP_NONE;
      RESP_VALID <= 1'b0;
    end
    else
    begin
      RESP_VALID <= 1'b0;
      RESP       <= ucs_pkg::RSP_NONE;
      if (state == ST_IDLE && TOK_VALID && is_ep0 && TOK.token == ucs_pkg::TOK_IN)
      begin
        RESP_VALID <= (mode != ucs_pkg::MODE_DISABLED && mode != ucs_pkg::MODE_IGNORE_INOUT);
        if (mode == ucs_pkg::MODE_NAK_INOUT)
          RESP <= ucs_pkg::RSP_NAK;
        else if (mode == ucs_pkg::MODE_STALL_INOUT)
          RESP <= ucs_pkg::RSP_STALL;
        else if (stin)
          RESP <= ucs_pkg::RSP_TX0;                                   // see RQ14
      end
      else if (state == ST_DATA && PKT_END)
      begin
        if (cur_tok == ucs_pkg::TOK_SETUP && setup_ok && good)
        begin
          RESP       <= ucs_pkg::RSP_ACK;                             // see RQ6
          RESP_VALID <= 1'b1;
        end
        else if (cur_tok == ucs_pkg::TOK_OUT && (PKT.ok || mode == ucs_pkg::MODE_NAK_INOUT ||
                 mode == ucs_pkg::MODE_STALL_INOUT))
        begin
          RESP_VALID <= 1'b1;
          if (mode == ucs_pkg::MODE_NAK_INOUT)
            RESP <= ucs_pkg::RSP_NAK;
          else if (mode == ucs_pkg::MODE_STALL_INOUT)
            RESP <= ucs_pkg::RSP_STALL;
          else if (big || mode == ucs_pkg::MODE_IGNORE_INOUT || mode == ucs_pkg::MODE_DISABLED)
            RESP_VALID <= 1'b0;                                       // see RQ13
          else if (out_ok)
            RESP <= ucs_pkg::RSP_ACK;                                 // see RQ9
          else if (mode == ucs_pkg::MODE_NAKOUT_STIN)
            RESP <= ucs_pkg::RSP_NAK;                                 // see RQ10
          else if (mode == ucs_pkg::MODE_STATUS_IN)
            RESP <= ucs_pkg::RSP_STALL;                               // see RQ11
          else
            RESP_VALID <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // mode and pid flags
  // ==========================================================
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      mode    <= ucs_pkg::MODE_RESET;                                 // see RQ12
      f_setup <= 1'b0;
      f_in    <= 1'b0;
      f_out   <= 1'b0;
      f_ack   <= 1'b0;
    end
    else
    begin
      if (wr_mode)
      begin
        mode    <= WDATA[3:0];
        f_setup <= WDATA[ucs_pkg::MODE_SETUP_BIT];
        f_in    <= WDATA[ucs_pkg::MODE_IN_BIT];
        f_out   <= WDATA[ucs_pkg::MODE_OUT_BIT];
        f_ack   <= WDATA[ucs_pkg::MODE_ACK_BIT];
      end
      if (state == ST_DATA && DAT_START && cur_tok == ucs_pkg::TOK_SETUP && setup_ok)
        f_setup <= 1'b1;                                              // see RQ1
      if (state == ST_IDLE && TOK_VALID && is_ep0 && TOK.token == ucs_pkg::TOK_IN &&
          mode != ucs_pkg::MODE_DISABLED && mode != ucs_pkg::MODE_IGNORE_INOUT)
        f_in <= 1'b1;                                                 // see RQ14
      if (state == ST_WAIT && HS_ACK)
        f_ack <= 1'b1;
      if (state == ST_DATA && PKT_END)
      begin
        if (cur_tok == ucs_pkg::TOK_SETUP && setup_ok && good)
        begin
          f_ack <= 1'b1;
          mode  <= ucs_pkg::MODE_NAK_INOUT;                           // see RQ6
        end
        else if (cur_tok == ucs_pkg::TOK_OUT)
        begin
          if (ev)
            f_out <= 1'b1;                                            // see RQ9 RQ10
          if (mode == ucs_pkg::MODE_ACKOUT_STIN && good)
          begin
            f_ack <= 1'b1;
            mode  <= ucs_pkg::MODE_NAKOUT_STIN;                       // see RQ9
          end
          else if (mode == ucs_pkg::MODE_STATUS_IN && good)
            mode <= ucs_pkg::MODE_STALL_INOUT;                        // see RQ11
        end
      end
    end
  end

  // ==========================================================
  // buffer, count, toggle, valid
  // ==========================================================
  logic store;
  assign store = (cur_tok == ucs_pkg::TOK_SETUP && setup_ok) || (cur_tok == ucs_pkg::TOK_OUT && out_ok);

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      wptr <= 4'h0;
    else if (state == ST_DATA && DAT_START)
      wptr <= 4'h0;
    else if (state == ST_DATA && BYTE_VALID && store && wptr != 4'(MAX_BYTES))
      wptr <= wptr + 4'h1;
  end

  // oversize packets overwrite the tail entry; buffer holds junk then
  always_ff @(posedge CLK)
  begin
    if (state == ST_DATA && BYTE_VALID && store)
      buffer[(wptr == 4'(MAX_BYTES)) ? 4'(MAX_BYTES - 1) : wptr] <= RX_BYTE.data;   // see RQ7
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      count  <= 4'h0;
      dval   <= 1'b0;
      toggle <= 1'b0;
    end
    else if (state == ST_DATA && PKT_END && store)
    begin
      count  <= big ? 4'hF : PKT.count[3:0];                          // see RQ7
      toggle <= PKT.toggle;                                           // see RQ8
      dval   <= PKT.ok;                                               // see RQ8
    end
    else if (wr_cnt)
    begin
      count  <= WDATA[3:0];
      dval   <= WDATA[ucs_pkg::CNT_DVAL_BIT];
      toggle <= WDATA[ucs_pkg::CNT_TOG_BIT];
    end
  end

  // ==========================================================
  // events and lock
  // ==========================================================
  always_comb
  begin
    ev       = 1'b0;
    ack_done = 1'b0;
    if (state == ST_DATA && PKT_END)
    begin
      if (cur_tok == ucs_pkg::TOK_SETUP && setup_ok)
        ev = 1'b1;                                                    // see RQ8
      else if (cur_tok == ucs_pkg::TOK_OUT)
        ev = (mode inside {ucs_pkg::MODE_NAK_INOUT, ucs_pkg::MODE_STALL_INOUT}) || out_ok ||
             (good && (mode inside {ucs_pkg::MODE_NAKOUT_STIN, ucs_pkg::MODE_STATUS_IN}));
      ack_done = store && good;
    end
    else if (state == ST_IDLE && TOK_VALID && is_ep0 && TOK.token == ucs_pkg::TOK_IN)
      ev = mode != ucs_pkg::MODE_DISABLED && mode != ucs_pkg::MODE_IGNORE_INOUT;   // see RQ14
    else if (state == ST_WAIT && HS_ACK)
      ack_done = 1'b1;                                                // see RQ2
  end

  assign ucs_hit_rd = RD && (ADDR == ucs_pkg::ADDR_MODE || ADDR == ucs_pkg::ADDR_COUNT);
  assign rd_stat    = RD && (ADDR == ucs_pkg::ADDR_IRQ);

  ucs_lock #(.LOCK_CYCLES(LOCK_CYCLES)) u_lock (
    .clk      (CLK),
    .rst_n    (RESETN),
    .ack_done (ack_done),
    .rd_hit   (ucs_hit_rd),
    .locked   (locked)
  );

  ucs_irq #(.W(8)) u_irq (
    .clk     (CLK),
    .rst_n   (RESETN),
    .set     ({7'h00, ev}),
    .rd_clr  (rd_stat),
    .mask_we (WR && ADDR == ucs_pkg::ADDR_MASK),
    .mask_d  (WDATA),
    .status  (irq_status),
    .mask    (irq_mask),
    .irq     (IRQ)
  );

  // ==========================================================
  // register read
  // ==========================================================
  always_comb
  begin
    next_rdata = 8'h00;
    if (ADDR == ucs_pkg::ADDR_MODE)
      next_rdata = {f_ack, f_out, f_in, f_setup, mode};               // see RQ5
    else if (ADDR == ucs_pkg::ADDR_COUNT)
      next_rdata = {toggle, dval, 2'b00, count};
    else if (ADDR == ucs_pkg::ADDR_STATUS)
      next_rdata = {6'h00, (state == ST_WAIT), locked};
    else if (ADDR == ucs_pkg::ADDR_IRQ)
      next_rdata = irq_status;
    else if (ADDR == ucs_pkg::ADDR_MASK)
      next_rdata = irq_mask;
    else if (ADDR >= ucs_pkg::ADDR_DATA && ADDR < ucs_pkg::ADDR_DATA + ucs_pkg::DATA_SPAN)
      next_rdata = buffer[4'(ADDR - ucs_pkg::ADDR_DATA)];
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      RDATA <= 8'h00;
    else
      RDATA <= RD ? next_rdata : 8'h00;
  end
endmodule : ucs_engine

// >>> core/ucs_pkg.sv
// Purpose: shared constants and types for the control endpoint engine
// Assumes: one clock at 250 MHz, active-low asynchronous reset
// Notes:   register word offsets are byte addresses on the plain port
package ucs_pkg;

  // ==========================================================
  // endpoint modes
  // ==========================================================
  localparam logic [3:0] MODE_DISABLED     = 4'h0;
  localparam logic [3:0] MODE_NAK_INOUT    = 4'h1;
  localparam logic [3:0] MODE_STALL_INOUT  = 4'h3;
  localparam logic [3:0] MODE_IGNORE_INOUT = 4'h4;
  localparam logic [3:0] MODE_STATUS_IN    = 4'h6;
  localparam logic [3:0] MODE_NAKOUT_STIN  = 4'hA;
  localparam logic [3:0] MODE_ACKOUT_STIN  = 4'hB;
  localparam logic [3:0] MODE_RESET        = MODE_DISABLED;

  // ==========================================================
  // register map
  // ==========================================================
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_COUNT  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ    = 8'h0C;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_DATA   = 8'h20;
  localparam logic [7:0] DATA_SPAN   = 8'h0A;

  // mode register layout: [3:0] mode, [4] setup, [5] in, [6] out, [7] ack
  localparam int MODE_SETUP_BIT = 4;
  localparam int MODE_IN_BIT    = 5;
  localparam int MODE_OUT_BIT   = 6;
  localparam int MODE_ACK_BIT   = 7;
  // count register layout: [3:0] count, [6] data valid, [7] toggle
  localparam int CNT_DVAL_BIT   = 6;
  localparam int CNT_TOG_BIT    = 7;

  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int         MAX_BYTES  = 10;

  // lock window about 1 us
  localparam int CLK_MHZ      = 250;
  localparam int LOCK_NS      = 1000;
  localparam int LOCK_CYCLES  = (LOCK_NS * CLK_MHZ) / 1000;

  // ==========================================================
  // link types
  // ==========================================================
  typedef enum logic [1:0]
  {
    TOK_SETUP = 2'h0,
    TOK_IN    = 2'h1,
    TOK_OUT   = 2'h2
  } ucs_token_t;

  typedef enum logic [2:0]
  {
    RSP_NONE  = 3'h0,
    RSP_ACK   = 3'h1,
    RSP_NAK   = 3'h2,
    RSP_STALL = 3'h3,
    RSP_TX0   = 3'h4
  } ucs_resp_t;

  typedef struct packed
  {
    ucs_token_t token;
    logic [3:0] ep;
  } ucs_tok_t;

  typedef struct packed
  {
    logic [7:0] data;
    logic       last;
  } ucs_byte_t;

  typedef struct packed
  {
    logic       ok;
    logic       toggle;
    logic [4:0] count;
  } ucs_pkt_t;

  // irq bits: [0] endpoint event
  localparam int IRQ_EP_BIT = 0;

endpackage : ucs_pkg

// >>> core/ucs_lock.sv
// Purpose: write interlock on mode and count registers
// Assumes: ack_done is a one-cycle pulse at end of an acked transaction
// Notes:   a mode or count read after the window unlocks; reads during the window do not
module ucs_lock #(
  parameter int LOCK_CYCLES = ucs_pkg::LOCK_CYCLES
) (
  input  wire logic clk,      // clock
  input  wire logic rst_n,    // async reset, low
  input  wire logic ack_done, // acked transaction finished
  input  wire logic rd_hit,   // cpu read of mode or count
  output logic      locked    // writes refused
);
  logic [9:0] hold;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      locked <= 1'b0;
    else if (ack_done)
      locked <= 1'b1;                                    // see RQ2
    else if (rd_hit && hold == 10'h000)
      locked <= 1'b0;                                    // see RQ3
  end

  // reads inside the settle window keep the lock, so firmware sees final state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hold <= 10'h000;
    else if (ack_done)
      hold <= 10'(LOCK_CYCLES);                          // see RQ4
    else if (hold != 10'h000)
      hold <= hold - 10'h001;
  end
endmodule : ucs_lock

// >>> core/ucs_irq.sv
// Purpose: sticky status and mask gating onto one interrupt line
// Assumes: read of status clears it; set wins over clear
// Notes:   width parameterised
module ucs_irq #(
  parameter int W = 8
) (
  input  wire logic         clk,     // clock
  input  wire logic         rst_n,   // async reset, low
  input  wire logic [W-1:0] set,     // event pulses
  input  wire logic         rd_clr,  // status read
  input  wire logic         mask_we, // mask write
  input  wire logic [W-1:0] mask_d,  // mask data
  output logic [W-1:0]      status,  // sticky bits
  output logic [W-1:0]      mask,    // mask
  output logic              irq      // level interrupt
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          status[i] <= 1'b0;
        else if (set[i])
          status[i] <= 1'b1;
        else if (rd_clr)
          status[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mask <= W'(ucs_pkg::MASK_RESET);
    else if (mask_we)
      mask <= mask_d;
  end

  assign irq = |(status & mask);
endmodule : ucs_irq

// >>> test/ucs_host.sv
// Purpose: low-speed host model issuing tokens, data packets and handshakes
// Assumes: the bench calls one task at a time, just after a rising edge
// Notes:   idle data lines show the inverse of their last value
module ucs_host (
  input  wire logic          CLK,        // clock
  output logic               TOK_VALID,  // token pulse
  output ucs_pkg::ucs_tok_t  TOK,        // token kind and endpoint
  output logic               DAT_START,  // data phase start
  output logic               BYTE_VALID, // byte pulse
  output ucs_pkg::ucs_byte_t RX_BYTE,    // received byte
  output logic               PKT_END,    // packet end
  output ucs_pkg::ucs_pkt_t  PKT,        // packet verdict
  output logic               HS_ACK      // host handshake
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
    {TOK_VALID, TOK, DAT_START, BYTE_VALID, RX_BYTE, PKT_END, PKT, HS_ACK} = '0;
  task automatic tok(input ucs_pkg::ucs_token_t k, input logic [3:0] ep);
    TOK_VALID <= 1'b1;
    TOK       <= '{k, ep};
    @(posedge CLK);
    TOK_VALID <= 1'b0;
    TOK       <= ~TOK;
  endtask : tok
  // count covers the crc bytes, so all of them are sent as bytes too
  task automatic pkt(input ucs_pkg::ucs_token_t k, input logic [4:0] n, input logic ok);
    tok(k, 4'h0);
    DAT_START <= 1'b1;
    @(posedge CLK);
    DAT_START <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      BYTE_VALID <= 1'b1;
      RX_BYTE    <= '{8'hA0 + 8'(i), i == n - 1};
      @(posedge CLK);
    end
    BYTE_VALID <= 1'b0;
    RX_BYTE    <= ~RX_BYTE;
    PKT_END    <= 1'b1;
    PKT        <= '{ok, 1'b1, n};
    @(posedge CLK);
    PKT_END    <= 1'b0;
    PKT        <= ~PKT;
  endtask : pkt
  task automatic ack();
    HS_ACK <= 1'b1;
    @(posedge CLK);
    HS_ACK <= 1'b0;
  endtask : ack
endmodule : ucs_host

// >>> test/ucs_checker.sv
// Purpose: port-level checks of the control endpoint engine
// Assumes: one clock domain, RESETN low clears everything
// Notes:   bound to every engine instance
module ucs_checker #(
  parameter int LOCK_CYCLES = 250
) (
  input wire logic               CLK,        // clock
  input wire logic               RESETN,     // reset, low
  input wire logic               TOK_VALID,  // token pulse
  input wire ucs_pkg::ucs_tok_t  TOK,        // token
  input wire logic               PKT_END,    // packet end
  input wire ucs_pkg::ucs_pkt_t  PKT,        // verdict
  input wire ucs_pkg::ucs_resp_t RESP,       // handshake
  input wire logic               RESP_VALID, // response pulse
  input wire logic [7:0]         ADDR,       // address
  input wire logic               RD,         // read strobe
  input wire logic [7:0]         RDATA       // read data
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic last_setup;
  int   since_ack;
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      last_setup <= 1'b0;
    else if (TOK_VALID)
      last_setup <= TOK.token == ucs_pkg::TOK_SETUP;
  // saturates so a long idle never wraps back into the window
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      since_ack <= LOCK_CYCLES;
    else if (RESP_VALID && RESP == ucs_pkg::RSP_ACK)
      since_ack <= 0;
    else if (since_ack < LOCK_CYCLES)
      since_ack <= since_ack + 1;
  sequence s_setup_end;
    PKT_END && last_setup;
  endsequence
  sequence s_lock_probe;
    RD && ADDR == ucs_pkg::ADDR_STATUS && since_ack < LOCK_CYCLES - 2;
  endsequence
  AST_BAD_SILENT: assert property (PKT_END && !PKT.ok |=> !RESP_VALID)
    else $error("handshake after a failed packet");
  AST_BIG_SILENT: assert property (PKT_END && PKT.count > 5'd10 |=> !RESP_VALID)
    else $error("handshake after an oversize packet");
  AST_SETUP_ACK: assert property (s_setup_end |=> !RESP_VALID || RESP == ucs_pkg::RSP_ACK)
    else $error("setup answered with other than ack");
  AST_LOCK_WINDOW: assert property (s_lock_probe |=> RDATA[0])
    else $error("lock released inside the window");
  AST_RESP_CAUSE: assert property (RESP_VALID |-> $past(TOK_VALID || PKT_END))
    else $error("response without token or packet end");
  AST_RESP_PULSE: assert property (RESP_VALID |=> !RESP_VALID)
    else $error("response pulse longer than one cycle");
  AST_IN_NO_ACK: assert property (TOK_VALID && TOK.token == ucs_pkg::TOK_IN |=>
    !RESP_VALID || RESP != ucs_pkg::RSP_ACK)
    else $error("in token answered with ack");
  AST_EP_IGNORE: assert property (TOK_VALID && TOK.ep != 4'h0 |=> !RESP_VALID)
    else $error("answer to a foreign endpoint");
  AST_RDATA_IDLE: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data outside read answer cycle");
endmodule : ucs_checker
bind ucs_engine ucs_checker #(.LOCK_CYCLES(LOCK_CYCLES)) i_chk (.CLK, .RESETN, .TOK_VALID, .TOK,
  .PKT_END, .PKT, .RESP, .RESP_VALID, .ADDR, .RD, .RDATA);

// >>> test/ucs_engine_tb.sv
// Purpose: self-checking bench of the control endpoint engine
// Assumes: short lock window so the run stays brief
// Notes:   host model drives the token side, tasks here act as firmware
module ucs_engine_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         LK     = 8;
  localparam logic [3:0] OM[3]  = '{ucs_pkg::MODE_ACKOUT_STIN, ucs_pkg::MODE_NAKOUT_STIN, ucs_pkg::MODE_STATUS_IN};
  localparam logic [3:0] NM[3]  = '{ucs_pkg::MODE_NAKOUT_STIN, ucs_pkg::MODE_NAKOUT_STIN, ucs_pkg::MODE_STALL_INOUT};
  localparam logic [7:0] AM = ucs_pkg::ADDR_MODE, AC = ucs_pkg::ADDR_COUNT, AI = ucs_pkg::ADDR_IRQ;
  localparam logic [7:0] AK = ucs_pkg::ADDR_MASK;
  logic CLK, RESETN, WR, RD, TOK_VALID, DAT_START, BYTE_VALID, PKT_END, HS_ACK, RESP_VALID, IRQ;
  logic [7:0]         ADDR, WDATA, RDATA;
  ucs_pkg::ucs_tok_t  TOK;
  ucs_pkg::ucs_byte_t RX_BYTE;
  ucs_pkg::ucs_pkt_t  PKT;
  ucs_pkg::ucs_resp_t RESP, rsp;
  int                 n_mismatch = 0, cmp_count = 0, cyc = 0;
  ucs_host i_host (.CLK, .TOK_VALID, .TOK, .DAT_START, .BYTE_VALID, .RX_BYTE, .PKT_END, .PKT, .HS_ACK);
  ucs_engine #(.LOCK_CYCLES(LK)) i_dut (.CLK, .RESETN, .TOK_VALID, .TOK, .DAT_START, .BYTE_VALID,
    .RX_BYTE, .PKT_END, .PKT, .HS_ACK, .RESP, .RESP_VALID, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ);
  initial
  begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK)
    if (RESP_VALID === 1'b1)
      rsp <= RESP;
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : idle
  // response stands one cycle; the capture lands one edge later
  task automatic exp_rsp(input ucs_pkg::ucs_resp_t r);
    idle(1);
    chk(8'(rsp), 8'(r));
    rsp = ucs_pkg::RSP_NONE;
  endtask : exp_rsp
  // ending off the edge keeps two strobes from landing in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= d;
    idle(1);
    WR    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    RD   <= 1'b1;
    ADDR <= a;
    idle(1);
    RD   <= 1'b0;
    d    = RDATA;
  endtask : rd
  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset();
    logic [7:0] d;
    rd(AM, d);
    chk(d, 8'h00);
    rd(AK, d);
    chk(d, ucs_pkg::MASK_RESET);
    i_host.pkt(ucs_pkg::TOK_SETUP, 5'd4, 1'b1);
    idle(2);
    exp_rsp(ucs_pkg::RSP_NONE);
    rd(AM, d);
    chk(d, 8'h00);
  endtask : t_reset
  task automatic t_setup();
    logic [7:0] d;
    wr(AK, 8'h01);
    wr(AM, {4'h0, ucs_pkg::MODE_ACKOUT_STIN});
    fork
      i_host.pkt(ucs_pkg::TOK_SETUP, 5'd10, 1'b1);
      begin
        idle(2);
        rd(AM, d);
        chk(d & 8'h90, 8'h10);
      end
    join
    idle(1);
    exp_rsp(ucs_pkg::RSP_ACK);
    rd(AM, d);
    chk(d, 8'h91);
    wr(AM, 8'h06);
    rd(ucs_pkg::ADDR_STATUS, d);
    chk(d & 8'h01, 8'h01);
    rd(AC, d);
    chk(d, 8'hCA);
    rd(ucs_pkg::ADDR_DATA, d);
    chk(d, 8'hA0);
    chk({7'h0, IRQ}, 8'h01);
    idle(LK);
    rd(AM, d);
    chk(d & 8'h0F, 8'h01);
    wr(AM, 8'h06);
    rd(AM, d);
    chk(d & 8'h0F, 8'h06);
    rd(AI, d);
    chk({d[0], IRQ}, 8'h02);
  endtask : t_setup
  task automatic t_bad_setup();
    logic [7:0] d;
    for (int i = 0; i < 2; i++)
    begin
      wr(AK, 8'h00);
      i_host.pkt(ucs_pkg::TOK_SETUP, i ? 5'd12 : 5'd4, i == 1);
      idle(2);
      exp_rsp(ucs_pkg::RSP_NONE);
      chk({7'h0, IRQ}, 8'h00);
      wr(AK, 8'h01);
      chk({7'h0, IRQ}, 8'h01);
      rd(AI, d);
      rd(AM, d);
      chk(d & 8'h1F, 8'h16);
      rd(AC, d);
      chk(d & (i ? 8'h0F : 8'h4F), i ? 8'h0F : 8'h04);
    end
  endtask : t_bad_setup
  task automatic t_out();
    logic [7:0]         d;
    ucs_pkg::ucs_resp_t r[3] = '{ucs_pkg::RSP_ACK, ucs_pkg::RSP_NAK, ucs_pkg::RSP_STALL};
    for (int i = 0; i < 3; i++)
    begin
      idle(LK);
      rd(AM, d);
      wr(AM, {4'h0, OM[i]});
      i_host.pkt(ucs_pkg::TOK_OUT, 5'd4, 1'b1);
      idle(1);
      exp_rsp(r[i]);
      rd(AM, d);
      chk(d & 8'h4F, {4'h4, NM[i]});
    end
  endtask : t_out
  task automatic t_in();
    logic [7:0] d;
    for (int i = 0; i < 3; i++)
    begin
      idle(LK);
      rd(AM, d);
      wr(AM, {4'h0, OM[i]});
      rd(AI, d);
      i_host.tok(ucs_pkg::TOK_IN, 4'h1);
      idle(1);
      exp_rsp(ucs_pkg::RSP_NONE);
      i_host.tok(ucs_pkg::TOK_IN, 4'h0);
      idle(1);
      exp_rsp(ucs_pkg::RSP_TX0);
      i_host.ack();
      rd(AI, d);
      chk(d, 8'h01);
    end
  endtask : t_in
  initial
  begin
    {RESETN, WR, RD, ADDR, WDATA} = '0;
    rsp = ucs_pkg::RSP_NONE;
    repeat (12) @(posedge CLK);
    RESETN <= 1'b1;
    idle(1);
    t_reset();
    t_setup();
    t_bad_setup();
    t_out();
    t_in();
    summarize();
  end
endmodule : ucs_engine_tb
